// File: verilog/tc0cf_regs.vh
// Register offsets, field positions and reset values of the timer 0 register block.
`ifndef TC0CF_REGS_VH
`define TC0CF_REGS_VH

// Data-space offsets of the five registers.
`define TC0CF_OFS_EVENT_FLAGS    8'h35
`define TC0CF_OFS_GENERAL_CTRL   8'h43
`define TC0CF_OFS_COUNT          8'h46
`define TC0CF_OFS_COMPARE_A      8'h47
`define TC0CF_OFS_COMPARE_B      8'h48

// Distance between a data-space offset and its short I/O address.
`define TC0CF_IO_SPACE_BASE      8'h20

// Fields of the general timer control register.
`define TC0CF_BIT_SYNC_MODE_HOLD 7
`define TC0CF_BIT_ASYNC_PRE_RST  1
`define TC0CF_BIT_SYNC_PRE_RST   0

// Fields of the event flag register.
`define TC0CF_BIT_COMPARE_B_FLAG 2
`define TC0CF_BIT_COMPARE_A_FLAG 1
`define TC0CF_BIT_OVERFLOW_FLAG  0

// Reset values.
`define TC0CF_RST_EVENT_FLAGS    3'h0
`define TC0CF_RST_GENERAL_CTRL   8'h00
`define TC0CF_RST_COUNT          8'h00
`define TC0CF_RST_COMPARE        8'h00

// Counter landmarks.
`define TC0CF_COUNT_MAX          8'hFF
`define TC0CF_COUNT_BOTTOM       8'h00

// Waveform mode encodings.
`define TC0CF_MODE_NORMAL        3'h0
`define TC0CF_MODE_PC_FIXED      3'h1
`define TC0CF_MODE_CTC           3'h2
`define TC0CF_MODE_FAST_FIXED    3'h3
`define TC0CF_MODE_RSVD_4        3'h4
`define TC0CF_MODE_PC_COMPARE    3'h5
`define TC0CF_MODE_RSVD_6        3'h6
`define TC0CF_MODE_FAST_COMPARE  3'h7

`endif

// File: verilog/tc0cf_timer0.v
// Timer 0 count, compare values, event flags and general prescaler control.
`timescale 1ns/1ps
`include "tc0cf_regs.vh"
module tc0cf_timer0 (
    input  wire       clk,
    input  wire       rstn,
    input  wire [7:0] bus_addr,
    input  wire       bus_io_space,
    input  wire       bus_wr,
    input  wire       bus_rd,
    input  wire [7:0] bus_wdata,
    output reg  [7:0] bus_rdata,
    input  wire       timer_tick,
    input  wire [2:0] waveform_mode_sel,
    input  wire       timer2_async_mode,
    input  wire       async_reset_done,
    input  wire       global_irq_enable,
    input  wire       compare_a_irq_enable,
    input  wire       compare_b_irq_enable,
    input  wire       overflow_irq_enable,
    input  wire       compare_a_vector_ack,
    input  wire       compare_b_vector_ack,
    input  wire       overflow_vector_ack,
    output wire       compare_a_irq,
    output wire       compare_b_irq,
    output wire       overflow_irq,
    output wire       compare_a_match,
    output wire       compare_b_match,
    output wire       sync_prescaler_rst,
    output wire       async_prescaler_rst,
    output wire       count_down
);

    // Register state.
    reg        sync_mode_hold_q;
    reg        sync_mode_hold_d;
    reg        async_prescaler_reset_q;
    reg        async_prescaler_reset_d;
    reg        sync_prescaler_reset_q;
    reg        sync_prescaler_reset_d;
    reg [7:0]  count_q;
    reg [7:0]  count_d;
    reg        dir_down_q;
    reg        dir_down_d;
    reg [7:0]  compare_a_q;
    reg [7:0]  compare_b_q;
    reg        compare_block_q;
    reg        compare_block_d;
    wire       compare_a_flag_q;
    wire       compare_b_flag_q;
    wire       overflow_flag_q;

    wire [7:0] eff_addr;
    wire       sel_flags;
    wire       sel_ctrl;
    wire       sel_count;
    wire       sel_cmp_a;
    wire       sel_cmp_b;
    wire       wr_flags;
    wire       wr_ctrl;
    wire       wr_count;
    wire       tick_en;
    wire       phase_mode;
    wire       top_is_compare;
    wire [7:0] top_value;
    wire       at_top;
    wire       at_bottom;
    reg        overflow_event;
    reg [7:0]  read_mux;
    wire [8:0] io_sum;
    wire [8:0] count_inc;
    wire [8:0] count_dec;
    wire       match_window;

    // Short I/O addresses sit 0x20 below the data-space offsets.
    assign io_sum   = {1'b0, bus_addr} + {1'b0, `TC0CF_IO_SPACE_BASE};
    // The carry is dropped on purpose: a wrapped sum lands below 0x20, where nothing is mapped.
    assign eff_addr = bus_io_space ? io_sum[7:0] : bus_addr;

    assign sel_flags = (eff_addr == `TC0CF_OFS_EVENT_FLAGS);
    assign sel_ctrl  = (eff_addr == `TC0CF_OFS_GENERAL_CTRL);
    assign sel_count = (eff_addr == `TC0CF_OFS_COUNT);
    assign sel_cmp_a = (eff_addr == `TC0CF_OFS_COMPARE_A);
    assign sel_cmp_b = (eff_addr == `TC0CF_OFS_COMPARE_B);

    assign wr_flags = bus_wr & sel_flags;
    assign wr_ctrl  = bus_wr & sel_ctrl;
    assign wr_count = bus_wr & sel_count;

    assign sync_prescaler_rst  = sync_prescaler_reset_q;
    assign async_prescaler_rst = async_prescaler_reset_q;

    // A held shared-prescaler reset stops timer 0 like its siblings.
    assign tick_en = timer_tick & ~sync_prescaler_reset_q;

    // General control: hold, hardware clear and async completion.
    always @* begin
        sync_mode_hold_d        = sync_mode_hold_q;
        async_prescaler_reset_d = async_prescaler_reset_q;
        sync_prescaler_reset_d  = sync_prescaler_reset_q;
        if (wr_ctrl) begin
            sync_mode_hold_d        = bus_wdata[`TC0CF_BIT_SYNC_MODE_HOLD];
            async_prescaler_reset_d = bus_wdata[`TC0CF_BIT_ASYNC_PRE_RST];
            sync_prescaler_reset_d  = bus_wdata[`TC0CF_BIT_SYNC_PRE_RST];
            if (sync_mode_hold_q && !bus_wdata[`TC0CF_BIT_SYNC_MODE_HOLD]) begin
                // Releasing the hold starts every timer in the same cycle.
                async_prescaler_reset_d = 1'b0;
                sync_prescaler_reset_d  = 1'b0;
            end
        end else if (!sync_mode_hold_q) begin
            // Reset bits stand for one cycle, then clear, unless held; in timer 2 async mode the async bit waits for async_reset_done.
            sync_prescaler_reset_d = 1'b0;
            if (!timer2_async_mode || async_reset_done) begin
                async_prescaler_reset_d = 1'b0;
            end
        end
        // With the hold set, only a control write changes the bits.
    end

    // Count sequencing for the waveform modes.
    assign phase_mode     = (waveform_mode_sel == `TC0CF_MODE_PC_FIXED) ||
                            (waveform_mode_sel == `TC0CF_MODE_PC_COMPARE);
    assign top_is_compare = (waveform_mode_sel == `TC0CF_MODE_CTC) ||
                            (waveform_mode_sel == `TC0CF_MODE_PC_COMPARE) ||
                            (waveform_mode_sel == `TC0CF_MODE_FAST_COMPARE);
    assign top_value      = top_is_compare ? compare_a_q : `TC0CF_COUNT_MAX;
    assign at_top         = (count_q == top_value);
    assign at_bottom      = (count_q == `TC0CF_COUNT_BOTTOM);
    assign count_down     = dir_down_q;
    assign count_inc      = {1'b0, count_q} + 9'h001;
    assign count_dec      = {1'b0, count_q} - 9'h001;

    always @* begin
        count_d    = count_q;
        dir_down_d = dir_down_q;
        if (wr_count) begin
            // A software write wins over a tick in the same cycle.
            count_d = bus_wdata;
        end else if (tick_en) begin
            if (phase_mode) begin
                if (!dir_down_q) begin
                    if (at_top) begin
                        dir_down_d = ~at_bottom;
                        count_d    = at_bottom ? count_q : count_dec[7:0];
                    end else begin
                        count_d = count_inc[7:0];
                    end
                end else if (at_bottom) begin
                    dir_down_d = 1'b0;
                    count_d    = count_inc[7:0];
                end else begin
                    count_d = count_dec[7:0];
                end
            end else if (at_top) begin
                count_d = `TC0CF_COUNT_BOTTOM;
            end else begin
                count_d = count_inc[7:0];
            end
        end
    end

    // Overflow point per mode.
    always @* begin
        overflow_event = 1'b0;
        if (tick_en && !wr_count) begin
            case (waveform_mode_sel)
                `TC0CF_MODE_PC_FIXED,
                `TC0CF_MODE_PC_COMPARE: begin
                    overflow_event = at_bottom & dir_down_q;
                end
                `TC0CF_MODE_FAST_COMPARE: begin
                    overflow_event = at_top;
                end
                default: begin
                    overflow_event = (count_q == `TC0CF_COUNT_MAX);
                end
            endcase
        end
    end

    // A count write blocks matches until the next tick has passed.
    always @* begin
        compare_block_d = compare_block_q;
        if (wr_count) begin
            compare_block_d = 1'b1;
        end else if (tick_en) begin
            compare_block_d = 1'b0;
        end
    end

    // Matches are taken on the timer tick, so a stopped timer raises none.
    assign match_window = tick_en & ~wr_count & ~compare_block_q;

    tc0cf_match_unit #(
        .WIDTH (8)
    ) u_match_a (
        .count     (count_q),
        .compare   (compare_a_q),
        .tick_live (match_window),
        .match     (compare_a_match)
    );

    tc0cf_match_unit #(
        .WIDTH (8)
    ) u_match_b (
        .count     (count_q),
        .compare   (compare_b_q),
        .tick_live (match_window),
        .match     (compare_b_match)
    );

    // Interrupt requests.
    assign compare_a_irq = global_irq_enable & compare_a_irq_enable & compare_a_flag_q;
    assign compare_b_irq = global_irq_enable & compare_b_irq_enable & compare_b_flag_q;
    assign overflow_irq  = global_irq_enable & overflow_irq_enable & overflow_flag_q;

    // Read data; unused bits are zero and unmapped offsets read zero.
    always @* begin
        read_mux = 8'h00;
        if (sel_flags) begin
            read_mux = {5'h00, compare_b_flag_q, compare_a_flag_q, overflow_flag_q};
        end else if (sel_ctrl) begin
            read_mux = {sync_mode_hold_q, 5'h00, async_prescaler_reset_q,
                        sync_prescaler_reset_q};
        end else if (sel_count) begin
            read_mux = count_q;
        end else if (sel_cmp_a) begin
            read_mux = compare_a_q;
        end else if (sel_cmp_b) begin
            read_mux = compare_b_q;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_mode_hold_q        <= 1'b0;
            async_prescaler_reset_q <= 1'b0;
            sync_prescaler_reset_q  <= 1'b0;
            count_q                 <= `TC0CF_RST_COUNT;
            dir_down_q              <= 1'b0;
            compare_a_q             <= `TC0CF_RST_COMPARE;
            compare_b_q             <= `TC0CF_RST_COMPARE;
            compare_block_q         <= 1'b0;
            bus_rdata               <= 8'h00;
        end else begin
            sync_mode_hold_q        <= sync_mode_hold_d;
            async_prescaler_reset_q <= async_prescaler_reset_d;
            sync_prescaler_reset_q  <= sync_prescaler_reset_d;
            count_q                 <= count_d;
            dir_down_q              <= dir_down_d;
            compare_block_q         <= compare_block_d;
            if (bus_wr && sel_cmp_a) begin
                compare_a_q <= bus_wdata;
            end
            if (bus_wr && sel_cmp_b) begin
                compare_b_q <= bus_wdata;
            end
            if (bus_rd) begin
                bus_rdata <= read_mux;
            end
        end
    end

    // Each flag is cleared by a one written at its own bit position or by its vector acknowledge.
    tc0cf_event_flag #(
        .RESET_VALUE (1'b0)
    ) u_flag_cmp_b (
        .clk          (clk),
        .rstn         (rstn),
        .set_event    (compare_b_match),
        .clear_write  (wr_flags & bus_wdata[`TC0CF_BIT_COMPARE_B_FLAG]),
        .clear_vector (compare_b_vector_ack),
        .flag_q       (compare_b_flag_q)
    );

    tc0cf_event_flag #(
        .RESET_VALUE (1'b0)
    ) u_flag_cmp_a (
        .clk          (clk),
        .rstn         (rstn),
        .set_event    (compare_a_match),
        .clear_write  (wr_flags & bus_wdata[`TC0CF_BIT_COMPARE_A_FLAG]),
        .clear_vector (compare_a_vector_ack),
        .flag_q       (compare_a_flag_q)
    );

    tc0cf_event_flag #(
        .RESET_VALUE (1'b0)
    ) u_flag_ovf (
        .clk          (clk),
        .rstn         (rstn),
        .set_event    (overflow_event),
        .clear_write  (wr_flags & bus_wdata[`TC0CF_BIT_OVERFLOW_FLAG]),
        .clear_vector (overflow_vector_ack),
        .flag_q       (overflow_flag_q)
    );

endmodule

// One event flag: set by hardware, cleared by a written one or by the vector.
module tc0cf_event_flag #(
    parameter [0:0] RESET_VALUE = 1'b0
) (
    input  wire clk,
    input  wire rstn,
    input  wire set_event,
    input  wire clear_write,
    input  wire clear_vector,
    output reg  flag_q
);

    // A new event wins over a clear in the same cycle, so no event is lost.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= RESET_VALUE;
        end else begin
            flag_q <= set_event | (flag_q & ~clear_write & ~clear_vector);
        end
    end

endmodule

// Equality compare of the count against one compare value, gated to the tick.
module tc0cf_match_unit #(
    parameter WIDTH = 8
) (
    input  wire [WIDTH-1:0] count,
    input  wire [WIDTH-1:0] compare,
    input  wire             tick_live,
    output wire             match
);

    assign match = tick_live & (count == compare);

endmodule

// File: bench/tc0cf_timer0_properties.sv
// Concurrent checks on the ports of the timer 0 register block.
`timescale 1ns/1ps
module tc0cf_timer0_properties (
    input logic       clk,
    input logic       rstn,
    input logic [7:0] bus_addr,
    input logic       bus_io_space,
    input logic       bus_wr,
    input logic       bus_rd,
    input logic [7:0] bus_wdata,
    input logic [7:0] bus_rdata,
    input logic       timer_tick,
    input logic       timer2_async_mode,
    input logic       global_irq_enable,
    input logic       compare_a_irq_enable,
    input logic       overflow_irq_enable,
    input logic       compare_a_irq,
    input logic       overflow_irq,
    input logic       compare_a_match,
    input logic       compare_b_match,
    input logic       sync_prescaler_rst,
    input logic       async_prescaler_rst
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Mirror of the hold bit: a write that releases the hold clears the reset bits at once.
    wire  ctl_wr = bus_wr && (bus_io_space ? bus_addr == 8'h23 : bus_addr == 8'h43);
    logic hold_m;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_m <= 1'b0;
        end else if (ctl_wr) begin
            hold_m <= bus_wdata[7];
        end
    end
    chk_hold_keeps: assert property (hold_m && !ctl_wr
        |=> $stable(sync_prescaler_rst) && $stable(async_prescaler_rst))
        else $error("prescaler reset bit changed under hold");
    chk_async_autoclr: assert property (ctl_wr && !hold_m && !bus_wdata[7] && bus_wdata[1]
        && !timer2_async_mode |=> async_prescaler_rst
        ##1 (!async_prescaler_rst || $past(ctl_wr || timer2_async_mode)))
        else $error("async reset bit not cleared after one cycle");
    chk_sync_autoclr: assert property (ctl_wr && !hold_m && !bus_wdata[7] && bus_wdata[0]
        |=> sync_prescaler_rst ##1 (!sync_prescaler_rst || $past(ctl_wr)))
        else $error("sync reset bit not cleared after one cycle");
    chk_halt_nomatch: assert property (sync_prescaler_rst
        |-> !compare_a_match && !compare_b_match) else $error("match while halted");
    chk_match_tick: assert property (compare_a_match || compare_b_match |-> timer_tick)
        else $error("match without timer tick");
    chk_wr_suppress: assert property ((bus_wr && !bus_io_space && bus_addr == 8'h46
        && !timer_tick) ##1 timer_tick |-> !compare_a_match && !compare_b_match)
        else $error("match on tick after count write");
    chk_irq_a_gate: assert property (compare_a_irq
        |-> global_irq_enable && compare_a_irq_enable) else $error("compare a irq ungated");
    chk_irq_ovf_gate: assert property (overflow_irq
        |-> global_irq_enable && overflow_irq_enable) else $error("overflow irq ungated");
    chk_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without read");
    chk_unmapped_zero: assert property (bus_rd && !bus_io_space && bus_addr == 8'h00
        |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind tc0cf_timer0 tc0cf_timer0_properties u_chk (.clk(clk), .rstn(rstn),
    .bus_addr(bus_addr), .bus_io_space(bus_io_space), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .timer_tick(timer_tick),
    .timer2_async_mode(timer2_async_mode), .global_irq_enable(global_irq_enable),
    .compare_a_irq_enable(compare_a_irq_enable), .overflow_irq_enable(overflow_irq_enable),
    .compare_a_irq(compare_a_irq), .overflow_irq(overflow_irq),
    .compare_a_match(compare_a_match), .compare_b_match(compare_b_match),
    .sync_prescaler_rst(sync_prescaler_rst), .async_prescaler_rst(async_prescaler_rst));

// File: bench/tb.sv
// Self-checking bench for the timer 0 register block.
`timescale 1ns/1ps
module tb;
    logic       clk = 1'b0, rstn = 1'b0, io = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic       tick_q = 1'b0, t2_async = 1'b0, done = 1'b0, gie = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, got;
    logic [2:0] mode = 3'h0, ien = 3'h0, ack = 3'h0;
    logic [7:0] ofs [5] = '{8'h35, 8'h43, 8'h46, 8'h47, 8'h48};
    wire  [7:0] bus_rdata;
    wire        irq_a, irq_b, irq_o, cnt_dn;
    int         n_errors = 0, checks_done = 0;
    always #10 clk = ~clk;
    tc0cf_timer0 dut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_io_space(io),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .timer_tick(tick_q), .waveform_mode_sel(mode), .timer2_async_mode(t2_async),
        .async_reset_done(done), .global_irq_enable(gie), .compare_a_irq_enable(ien[1]),
        .compare_b_irq_enable(ien[2]), .overflow_irq_enable(ien[0]),
        .compare_a_vector_ack(ack[1]), .compare_b_vector_ack(ack[2]),
        .overflow_vector_ack(ack[0]), .compare_a_irq(irq_a), .compare_b_irq(irq_b),
        .overflow_irq(irq_o), .compare_a_match(), .compare_b_match(),
        .sync_prescaler_rst(), .async_prescaler_rst(), .count_down(cnt_dn));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        cmp(what, exp, bus_rdata);
    endtask
    // Holds the tick high for n edges; entered at a falling edge right after a bus task.
    task automatic tick(input int n);
        tick_q = 1'b1;
        repeat (n) @(negedge clk);
        tick_q = 1'b0;
    endtask
    task automatic pulse_ack(input logic [2:0] which);
        ack = which;
        @(negedge clk);
        ack = 3'h0;
    endtask
    task automatic close_out;
        $display("Checks made: %0d, mismatches: %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        close_out;
    end
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        for (int k = 0; k < 5; k++) begin
            chk("reset value", ofs[k], 8'h00);
        end
        chk("unmapped", 8'h00, 8'h00);
        wr(8'h46, 8'h5A);
        wr(8'h47, 8'hA5);
        wr(8'h48, 8'h3C);
        io = 1'b1;
        chk("count io", 8'h26, 8'h5A);
        chk("cmp a io", 8'h27, 8'hA5);
        chk("cmp b io", 8'h28, 8'h3C);
        wr(8'h15, 8'hF8);
        chk("flag spare", 8'h15, 8'h00);
        io = 1'b0;
        wr(8'h43, 8'h7C);
        chk("ctrl spare", 8'h43, 8'h00);
        wr(8'h43, 8'h83);
        tick(4);
        chk("count halted", 8'h46, 8'h5A);
        chk("ctrl held", 8'h43, 8'h83);
        wr(8'h43, 8'h03);
        chk("ctrl release", 8'h43, 8'h00);
        wr(8'h43, 8'h03);
        chk("ctrl autoclr", 8'h43, 8'h00);
        t2_async = 1'b1;
        wr(8'h43, 8'h02);
        chk("async pending", 8'h43, 8'h02);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("async done", 8'h43, 8'h00);
        t2_async = 1'b0;
        wr(8'h47, 8'hFF);
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            pulse_ack(3'h7);
            wr(8'h46, 8'hFF);
            tick(1);
            chk("ovf at max", 8'h35, (m == 1 || m == 5) ? 8'h00 : 8'h01);
            if (m == 1 || m == 5) begin
                cmp("count down", 8'h01, {7'h00, cnt_dn});
                wr(8'h46, 8'h01);
                tick(2);
                chk("ovf at bottom", 8'h35, 8'h01);
            end
        end
        mode = 3'h0;
        pulse_ack(3'h7);
        wr(8'h46, 8'hFE);
        tick(2);
        chk("ovf flag", 8'h35, 8'h03);
        chk("count wrap", 8'h46, 8'h00);
        gie = 1'b1;
        ien = 3'h3;
        #1;
        cmp("ovf irq", 8'h01, {7'h00, irq_o});
        gie = 1'b0;
        #1;
        cmp("ovf irq masked", 8'h00, {7'h00, irq_o});
        pulse_ack(3'h3);
        wr(8'h47, 8'hA5);
        wr(8'h48, 8'hA5);
        wr(8'h46, 8'hA4);
        tick(2);
        chk("both match", 8'h35, 8'h06);
        gie = 1'b1;
        #1;
        cmp("cmp a irq", 8'h01, {7'h00, irq_a});
        cmp("cmp b irq off", 8'h00, {7'h00, irq_b});
        ien = 3'h7;
        #1;
        cmp("cmp b irq", 8'h01, {7'h00, irq_b});
        wr(8'h35, 8'h03);
        chk("w1c", 8'h35, 8'h04);
        pulse_ack(3'h4);
        chk("vector clear", 8'h35, 8'h00);
        wr(8'h46, 8'hA5);
        tick(1);
        chk("suppressed", 8'h35, 8'h00);
        close_out;
    end
endmodule
